// ==== verilog/artlc_pkg.sv ====
// Summary of operation
// RULE1 - 16-bit counter, split bit selects two 8-bit
// RULE2 - sources: system clock, divided by 12, external/8
// RULE3 - external divided source synchronised before counting
// RULE4 - 16-bit wrap loads both reload bytes
// RULE5 - 16-bit wrap sets high overflow flag
// RULE6 - timer irq enable requests irq per wrap
// RULE7 - low irq enable adds low byte wrap irq
// RULE8 - split halves reload from own reload bytes
// RULE9 - split mode: run bit gates high half only
// RULE10 - per half clock select with external select
// RULE11 - split wraps set high and low flags
// RULE12 - split irq: high wrap, either with low enable
// RULE13 - flags cleared only by software writes
// RULE14 - software reads both flags for irq source
// RULE15 - software keeps split zero during capture
// RULE16 - oscillator fall copies count, sets high flag
// RULE17 - capture source chosen by low clock select
// RULE18 - software uses fast clock, differences captures
// RULE19 - 16-bit mode counts only while run set
// RULE20 - low flag set on every low wrap
// RULE21 - oscillator synchronised, one capture per fall
// RULE22 - reset clears counts, reloads, flags, modes
package artlc_pkg;

   // ---------------------------------------------------------------
   // register map, byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] ARTLC_OFF_CNT_LO = 8'h00; // count_low_byte
   localparam logic [7:0] ARTLC_OFF_CNT_HI = 8'h04; // count_high_byte
   localparam logic [7:0] ARTLC_OFF_RL_LO = 8'h08; // reload_low_byte
   localparam logic [7:0] ARTLC_OFF_RL_HI = 8'h0c; // reload_high_byte
   localparam logic [7:0] ARTLC_OFF_CTRL = 8'h10; // timer_control_register
   localparam logic [7:0] ARTLC_OFF_CLK = 8'h14; // clock_control_register
   localparam logic [7:0] ARTLC_OFF_IEN = 8'h18; // interrupt_enable_register

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int ARTLC_B_HFLAG = 7; // high_overflow_flag
   localparam int ARTLC_B_LFLAG = 6; // low_overflow_flag
   localparam int ARTLC_B_LIRQ = 5; // low_byte_irq_enable
   localparam int ARTLC_B_CAP = 4; // osc_capture_enable
   localparam int ARTLC_B_SPLIT = 3; // split_mode_select
   localparam int ARTLC_B_RUN = 2; // run_control_bit
   localparam int ARTLC_B_EXT = 0; // external_source_select
   localparam int ARTLC_B_LCLK = 4; // low_half_clock_select
   localparam int ARTLC_B_HCLK = 5; // high_half_clock_select
   localparam int ARTLC_B_TIEN = 5; // timer irq enable

   // ---------------------------------------------------------------
   // reset values and counts
   // ---------------------------------------------------------------
   localparam logic [7:0] ARTLC_BYTE_RST = 8'h00; // counts and reloads
   localparam logic [7:0] ARTLC_BYTE_MAX = 8'hff; // wrap point of a byte
   localparam int ARTLC_DIV_SYS = 12; // system clock prescale
   localparam int ARTLC_DIV_EXT = 8; // external clock prescale
   localparam logic [1:0] ARTLC_RESP_OKAY = 2'b00;
   localparam logic [1:0] ARTLC_RESP_SLVERR = 2'b10;

   // mode bits of the control register, all reset to zero
   typedef struct packed {
      logic low_byte_irq_enable;
      logic osc_capture_enable;
      logic split_mode_select;
      logic run_control_bit;
      logic external_source_select;
   } artlc_ctrl_t;

   localparam artlc_ctrl_t ARTLC_CTRL_RST = '0;

endpackage : artlc_pkg

// ==== verilog/artlc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// two-flop synchroniser, one per bit
// ------------------------------------------------------------------
module artlc_sync #(
   parameter int W = 2 // number of bits
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_reg; // first stage, read only by second stage

   // both stages clear together so no false edge follows reset
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule : artlc_sync
`default_nettype wire

// ==== verilog/artlc_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// prescaler: one output pulse every DIV input pulses
// ------------------------------------------------------------------
module artlc_tick #(
   parameter int DIV = 12 // division ratio
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic tick_in,
   output logic tick_out
);

   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_reg; // input pulses seen so far

   // pulse is combinational so it lines up with the input pulse
   assign tick_out = tick_in && (cnt_reg == LAST);

   // count input pulses, wrap at the ratio
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_reg <= '0;
      end else if (tick_in) begin
         cnt_reg <= (cnt_reg == LAST) ? '0 : CW'(cnt_reg + 1'b1);
      end
   end

endmodule : artlc_tick
`default_nettype wire

// ==== verilog/artlc_timer.sv ====
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module artlc_timer
   import artlc_pkg::*;
#(
   parameter int ADDR_W = 8 // byte address width of the slave
) (
   input wire logic clk,
   input wire logic srst,
   // external precision oscillator and low-frequency oscillator
   input wire logic ext_osc_in,
   input wire logic low_freq_oscillator,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // timer interrupt request, level
   output logic irq_req
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [7:0] cnt_lo_reg; // count_low_byte
   logic [7:0] cnt_hi_reg; // count_high_byte
   logic [7:0] rl_lo_reg; // reload_low_byte
   logic [7:0] rl_hi_reg; // reload_high_byte
   logic hflag_reg; // high_overflow_flag
   logic lflag_reg; // low_overflow_flag
   artlc_ctrl_t ctrl_reg; // mode bits of the control register
   logic lclk_sel_reg; // low_half_clock_select
   logic hclk_sel_reg; // high_half_clock_select
   logic tien_reg; // timer irq enable

   // bus side holding registers
   logic aw_hold_reg; // write address captured
   logic [ADDR_W-1:0] aw_addr_reg;
   logic w_hold_reg; // write data captured
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   // ---------------------------------------------------------------
   // input synchronisers and edge detect
   // ---------------------------------------------------------------
   logic [1:0] sync_s; // {lfo, ext} after two flops
   logic lfo_d_reg; // delayed synchronised lfo
   logic ext_d_reg; // delayed synchronised external clock
   logic lfo_fall; // one pulse per lfo falling edge
   logic ext_rise; // one pulse per external clock rising edge

   artlc_sync #(.W(2)) u_sync (
      .clk(clk),
      .srst(srst),
      .async_in({low_freq_oscillator, ext_osc_in}),
      .sync_out(sync_s)
   );

   // edge detectors look only at the second flop stage
   always_ff @(posedge clk) begin
      if (srst) begin
         lfo_d_reg <= 1'b0;
         ext_d_reg <= 1'b0;
      end else begin
         lfo_d_reg <= sync_s[1];
         ext_d_reg <= sync_s[0];
      end
   end

   assign lfo_fall = lfo_d_reg && !sync_s[1]; // RULE21
   assign ext_rise = sync_s[0] && !ext_d_reg; // RULE3

   // ---------------------------------------------------------------
   // increment sources
   // ---------------------------------------------------------------
   logic div12_tick; // system clock / 12
   logic ext8_tick; // external clock / 8, already in clk domain
   logic lo_tick; // source picked for the low half
   logic hi_tick; // source picked for the high half

   artlc_tick #(.DIV(ARTLC_DIV_SYS)) u_div12 (
      .clk(clk),
      .srst(srst),
      .tick_in(1'b1),
      .tick_out(div12_tick)
   );

   // external clock must run well below clk/2 to be seen at all
   artlc_tick #(.DIV(ARTLC_DIV_EXT)) u_div8 (
      .clk(clk),
      .srst(srst),
      .tick_in(ext_rise),
      .tick_out(ext8_tick)
   );

   // clock select 1 means every system clock; RULE2 RULE10 RULE17
   assign lo_tick = lclk_sel_reg ? 1'b1 :
                    (ctrl_reg.external_source_select ? ext8_tick : div12_tick);
   assign hi_tick = hclk_sel_reg ? 1'b1 :
                    (ctrl_reg.external_source_select ? ext8_tick : div12_tick);

   // ---------------------------------------------------------------
   // count events
   // ---------------------------------------------------------------
   logic split; // two 8-bit timers
   logic inc16; // 16-bit mode advance
   logic inc_lo; // low half advances this cycle
   logic inc_hi_s; // high half advances in split mode
   logic lo_wrap; // low byte advances from ff, to 00 or to its reload
   logic wrap16; // full 16-bit wrap
   logic hi_wrap_s; // split high half wrap
   logic cap_evt; // capture this cycle

   assign split = ctrl_reg.split_mode_select; // RULE1
   assign inc16 = !split && ctrl_reg.run_control_bit && lo_tick; // RULE19
   assign inc_lo = split ? lo_tick : inc16; // RULE9
   assign inc_hi_s = split && ctrl_reg.run_control_bit && hi_tick; // RULE9
   assign lo_wrap = inc_lo && (cnt_lo_reg == ARTLC_BYTE_MAX);
   assign wrap16 = inc16 && ({cnt_hi_reg, cnt_lo_reg} == {ARTLC_BYTE_MAX, ARTLC_BYTE_MAX});
   assign hi_wrap_s = inc_hi_s && (cnt_hi_reg == ARTLC_BYTE_MAX);
   assign cap_evt = ctrl_reg.osc_capture_enable && lfo_fall; // RULE16

   // ---------------------------------------------------------------
   // write decode
   // ---------------------------------------------------------------
   logic wr_fire; // both halves of a write present
   logic wr_b0; // byte lane 0 enabled
   logic wr_cnt_lo, wr_cnt_hi, wr_rl_lo, wr_rl_hi, wr_ctrl, wr_clk, wr_ien;
   logic wr_hit; // write address is mapped
   logic [7:0] wd; // low byte of write data

   assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign wr_b0 = wr_fire && w_strb_reg[0];
   assign wd = w_data_reg[7:0];
   assign wr_cnt_lo = wr_b0 && (aw_addr_reg[7:2] == ARTLC_OFF_CNT_LO[7:2]);
   assign wr_cnt_hi = wr_b0 && (aw_addr_reg[7:2] == ARTLC_OFF_CNT_HI[7:2]);
   assign wr_rl_lo = wr_b0 && (aw_addr_reg[7:2] == ARTLC_OFF_RL_LO[7:2]);
   assign wr_rl_hi = wr_b0 && (aw_addr_reg[7:2] == ARTLC_OFF_RL_HI[7:2]);
   assign wr_ctrl = wr_b0 && (aw_addr_reg[7:2] == ARTLC_OFF_CTRL[7:2]);
   assign wr_clk = wr_b0 && (aw_addr_reg[7:2] == ARTLC_OFF_CLK[7:2]);
   assign wr_ien = wr_b0 && (aw_addr_reg[7:2] == ARTLC_OFF_IEN[7:2]);
   assign wr_hit = (aw_addr_reg[7:2] <= ARTLC_OFF_IEN[7:2]);

   // ---------------------------------------------------------------
   // counter bytes
   // ---------------------------------------------------------------
   // low byte; a software write beats a count in the same cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_lo_reg <= ARTLC_BYTE_RST; // RULE22
      end else if (wr_cnt_lo) begin
         cnt_lo_reg <= wd;
      end else if (inc_lo) begin
         if (cnt_lo_reg != ARTLC_BYTE_MAX) begin
            cnt_lo_reg <= cnt_lo_reg + 8'h01;
         end else if (split || wrap16) begin
            cnt_lo_reg <= rl_lo_reg; // RULE4 RULE8
         end else begin
            cnt_lo_reg <= ARTLC_BYTE_RST;
         end
      end
   end

   // high byte: carry from the low byte, or its own source when split
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_hi_reg <= ARTLC_BYTE_RST; // RULE22
      end else if (wr_cnt_hi) begin
         cnt_hi_reg <= wd;
      end else if (split) begin
         if (inc_hi_s) begin
            cnt_hi_reg <= hi_wrap_s ? rl_hi_reg : cnt_hi_reg + 8'h01; // RULE8
         end
      end else if (lo_wrap) begin
         cnt_hi_reg <= wrap16 ? rl_hi_reg : cnt_hi_reg + 8'h01; // RULE4
      end
   end

   // ---------------------------------------------------------------
   // reload bytes
   // ---------------------------------------------------------------
   // capture wins over a software write landing in the same cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         rl_lo_reg <= ARTLC_BYTE_RST; // RULE22
         rl_hi_reg <= ARTLC_BYTE_RST;
      end else if (cap_evt) begin
         rl_lo_reg <= cnt_lo_reg; // RULE16
         rl_hi_reg <= cnt_hi_reg;
      end else begin
         if (wr_rl_lo) begin
            rl_lo_reg <= wd;
         end
         if (wr_rl_hi) begin
            rl_hi_reg <= wd;
         end
      end
   end

   // ---------------------------------------------------------------
   // overflow flags
   // ---------------------------------------------------------------
   // hardware set beats the software clear; no self clear
   always_ff @(posedge clk) begin
      if (srst) begin
         hflag_reg <= 1'b0;
         lflag_reg <= 1'b0;
      end else begin
         if (wrap16 || hi_wrap_s || cap_evt) begin
            hflag_reg <= 1'b1; // RULE5 RULE11 RULE16
         end else if (wr_ctrl) begin
            hflag_reg <= wd[ARTLC_B_HFLAG]; // RULE13
         end
         if (lo_wrap) begin
            lflag_reg <= 1'b1; // RULE11 RULE20
         end else if (wr_ctrl) begin
            lflag_reg <= wd[ARTLC_B_LFLAG]; // RULE13
         end
      end
   end

   // ---------------------------------------------------------------
   // mode and enable bits
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_reg <= ARTLC_CTRL_RST; // RULE22
         lclk_sel_reg <= 1'b0;
         hclk_sel_reg <= 1'b0;
         tien_reg <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg.low_byte_irq_enable <= wd[ARTLC_B_LIRQ];
            ctrl_reg.osc_capture_enable <= wd[ARTLC_B_CAP];
            ctrl_reg.split_mode_select <= wd[ARTLC_B_SPLIT];
            ctrl_reg.run_control_bit <= wd[ARTLC_B_RUN];
            ctrl_reg.external_source_select <= wd[ARTLC_B_EXT];
         end
         if (wr_clk) begin
            lclk_sel_reg <= wd[ARTLC_B_LCLK];
            hclk_sel_reg <= wd[ARTLC_B_HCLK];
         end
         if (wr_ien) begin
            tien_reg <= wd[ARTLC_B_TIEN];
         end
      end
   end

   // request stays up while an enabled flag is set; RULE6 RULE7 RULE12
   assign irq_req = tien_reg && (hflag_reg || (ctrl_reg.low_byte_irq_enable && lflag_reg));

   // ---------------------------------------------------------------
   // axi4-lite write channels
   // ---------------------------------------------------------------
   assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
   assign s_axi_wready = !w_hold_reg && !bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // address and data are caught separately, in either order
   always_ff @(posedge clk) begin
      if (srst) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_hold_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else if (wr_fire) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
      end
   end

   // response raised on the same edge that the write lands
   always_ff @(posedge clk) begin
      if (srst) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= ARTLC_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_hit ? ARTLC_RESP_OKAY : ARTLC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite read channels
   // ---------------------------------------------------------------
   logic [31:0] rd_mux; // read data for the presented address
   logic rd_hit; // read address is mapped

   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // unused and upper bits read as zero
   always_comb begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b1;
      unique case (s_axi_araddr[7:2])
         ARTLC_OFF_CNT_LO[7:2]: rd_mux[7:0] = cnt_lo_reg;
         ARTLC_OFF_CNT_HI[7:2]: rd_mux[7:0] = cnt_hi_reg;
         ARTLC_OFF_RL_LO[7:2]: rd_mux[7:0] = rl_lo_reg;
         ARTLC_OFF_RL_HI[7:2]: rd_mux[7:0] = rl_hi_reg;
         ARTLC_OFF_CTRL[7:2]: begin
            rd_mux[ARTLC_B_HFLAG] = hflag_reg; // RULE14
            rd_mux[ARTLC_B_LFLAG] = lflag_reg;
            rd_mux[ARTLC_B_LIRQ] = ctrl_reg.low_byte_irq_enable;
            rd_mux[ARTLC_B_CAP] = ctrl_reg.osc_capture_enable;
            rd_mux[ARTLC_B_SPLIT] = ctrl_reg.split_mode_select;
            rd_mux[ARTLC_B_RUN] = ctrl_reg.run_control_bit;
            rd_mux[ARTLC_B_EXT] = ctrl_reg.external_source_select;
         end
         ARTLC_OFF_CLK[7:2]: begin
            rd_mux[ARTLC_B_LCLK] = lclk_sel_reg;
            rd_mux[ARTLC_B_HCLK] = hclk_sel_reg;
         end
         ARTLC_OFF_IEN[7:2]: rd_mux[ARTLC_B_TIEN] = tien_reg;
         default: rd_hit = 1'b0;
      endcase
   end

   // read data registered on the address handshake
   always_ff @(posedge clk) begin
      if (srst) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= ARTLC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_mux;
         rresp_reg <= rd_hit ? ARTLC_RESP_OKAY : ARTLC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_wrap_reload: assert property (wrap16 && !wr_cnt_lo && !wr_cnt_hi // RULE4
      |=> {cnt_hi_reg, cnt_lo_reg} == {$past(rl_hi_reg), $past(rl_lo_reg)})
      else $error("16-bit wrap did not reload");
   a_high_flag: assert property ((wrap16 || hi_wrap_s) |=> hflag_reg) // RULE5
      else $error("high flag not set on wrap");
   a_low_flag: assert property (lo_wrap |=> lflag_reg) // RULE20
      else $error("low flag not set on low wrap");
   a_flag_hold: assert property (hflag_reg && !wr_ctrl |=> hflag_reg) // RULE13
      else $error("high flag cleared without write");
   a_split_low_free: assert property (split && lo_tick && !wr_cnt_lo // RULE9
      && cnt_lo_reg != ARTLC_BYTE_MAX |=> cnt_lo_reg == $past(cnt_lo_reg) + 8'h01)
      else $error("split low half did not advance");
   a_run_gate: assert property (!split && !ctrl_reg.run_control_bit // RULE19
      && !wr_cnt_lo && !wr_cnt_hi |=> $stable({cnt_hi_reg, cnt_lo_reg}))
      else $error("16-bit count moved while stopped");
   a_irq_high: assert property ($rose(hflag_reg) && tien_reg |-> irq_req) // RULE6
      else $error("no irq on high flag");
   a_capture_copy: assert property (cap_evt |=> hflag_reg // RULE16
      && {rl_hi_reg, rl_lo_reg} == $past({cnt_hi_reg, cnt_lo_reg}))
      else $error("capture did not copy count");
   a_div12_gap: assert property (div12_tick |=> !div12_tick [*8] ##1 !div12_tick [*3]) // RULE2
      else $error("divide by 12 pulse too early");
   a_lfo_once: assert property (lfo_fall |=> !lfo_fall) // RULE21
      else $error("double capture on one edge");
   a_reset_clear: assert property (@(posedge clk) disable iff (1'b0) srst // RULE22
      |=> {cnt_hi_reg, cnt_lo_reg, rl_hi_reg, rl_lo_reg} == 32'h00000000
      && !hflag_reg && !lflag_reg && ctrl_reg == ARTLC_CTRL_RST)
      else $error("reset left state set");

endmodule : artlc_timer
`default_nettype wire

// ==== verif/tb_artlc_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_artlc_timer;
   import artlc_pkg::*;
   // ---------------------------------------------------------------
   // stimulus and bus signals
   // ---------------------------------------------------------------
   logic clk = 1'b0;
   logic srst = 1'b1; // held for the first 12 edges
   logic ext_osc_in = 1'b0, slow_osc = 1'b0; // both idle low
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq_req;
   logic [1:0] bresp, rresp;
   int num_errors = 0, n_checks = 0;
   artlc_timer DUT (.clk(clk), .srst(srst), .ext_osc_in(ext_osc_in),
      .low_freq_oscillator(slow_osc), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_req(irq_req));
   always #5 clk = ~clk; // 100 mhz
   // ---------------------------------------------------------------
   // checking and bus tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish();
      if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge clk); // keeps bready from being set in the step that lowered it
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h0, d};
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
      if (n == 40) begin
         num_errors++;
         tally_and_finish();
      end
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      int n;
      @(posedge clk); // keeps rready from being set in the step that lowered it
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      chk(rdata, {24'h0, e});
      chk({30'h0, rresp}, {30'h0, er});
      if (n == 40) begin
         num_errors++;
         tally_and_finish();
      end
   endtask : rd
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      cyc(12);
      srst <= 1'b0;
      cyc(1);
      for (int i = 0; i < 7; i++) rd(8'(4 * i), 8'h00, 2'b00);
      rd(8'h1c, 8'h00, 2'b10); // unmapped place answers with an error
      wr(8'h1c, 8'h5a, 2'b10);
      // 16-bit run on the system clock through a full wrap
      wr(ARTLC_OFF_RL_LO, 8'h34, 2'b00);
      wr(ARTLC_OFF_RL_HI, 8'h12, 2'b00);
      wr(ARTLC_OFF_CNT_LO, 8'hf0, 2'b00);
      wr(ARTLC_OFF_CNT_HI, 8'hff, 2'b00);
      wr(ARTLC_OFF_CLK, 8'h10, 2'b00);
      wr(ARTLC_OFF_CTRL, 8'h04, 2'b00);
      cyc(20);
      rd(ARTLC_OFF_CTRL, 8'hc4, 2'b00);
      rd(ARTLC_OFF_CNT_HI, 8'h12, 2'b00);
      wr(ARTLC_OFF_IEN, 8'h20, 2'b00);
      chk({31'h0, irq_req}, 32'h1);
      wr(ARTLC_OFF_CTRL, 8'h00, 2'b00); // stop and clear both flags
      chk({31'h0, irq_req}, 32'h0);
      wr(ARTLC_OFF_CNT_LO, 8'h77, 2'b00);
      cyc(30);
      rd(ARTLC_OFF_CNT_LO, 8'h77, 2'b00);
      // split: low half runs without the run bit, high half held
      wr(ARTLC_OFF_CNT_LO, 8'hfa, 2'b00);
      wr(ARTLC_OFF_CNT_HI, 8'hfa, 2'b00);
      wr(ARTLC_OFF_CLK, 8'h30, 2'b00);
      wr(ARTLC_OFF_CTRL, 8'h08, 2'b00);
      cyc(20);
      rd(ARTLC_OFF_CTRL, 8'h48, 2'b00);
      rd(ARTLC_OFF_CNT_HI, 8'hfa, 2'b00);
      chk({31'h0, irq_req}, 32'h0);
      wr(ARTLC_OFF_CTRL, 8'h6c, 2'b00); // low irq on, run high half too
      chk({31'h0, irq_req}, 32'h1);
      cyc(20);
      rd(ARTLC_OFF_CTRL, 8'hec, 2'b00);
      // capture on a fall of the slow oscillator
      wr(ARTLC_OFF_CTRL, 8'h00, 2'b00);
      wr(ARTLC_OFF_CLK, 8'h10, 2'b00);
      wr(ARTLC_OFF_CNT_HI, 8'h55, 2'b00);
      wr(ARTLC_OFF_CNT_LO, 8'h00, 2'b00);
      wr(ARTLC_OFF_CTRL, 8'h14, 2'b00);
      slow_osc <= 1'b1;
      cyc(8);
      slow_osc <= 1'b0;
      cyc(10);
      rd(ARTLC_OFF_CTRL, 8'h94, 2'b00);
      rd(ARTLC_OFF_RL_HI, 8'h55, 2'b00);
      // external source: still pin means no count, 16 rises give 2
      wr(ARTLC_OFF_CTRL, 8'h00, 2'b00);
      wr(ARTLC_OFF_CLK, 8'h00, 2'b00);
      wr(ARTLC_OFF_CNT_LO, 8'h00, 2'b00);
      wr(ARTLC_OFF_CTRL, 8'h05, 2'b00);
      cyc(40);
      rd(ARTLC_OFF_CNT_LO, 8'h00, 2'b00);
      repeat (32) begin
         ext_osc_in <= ~ext_osc_in; // each level lasts 3 clocks
         cyc(3);
      end
      cyc(10);
      rd(ARTLC_OFF_CNT_LO, 8'h02, 2'b00);
      // divide by 12: the two control writes land 24 edges apart, so 2 ticks
      wr(ARTLC_OFF_CTRL, 8'h00, 2'b00);
      wr(ARTLC_OFF_CNT_LO, 8'h00, 2'b00);
      wr(ARTLC_OFF_CTRL, 8'h04, 2'b00);
      cyc(20);
      wr(ARTLC_OFF_CTRL, 8'h00, 2'b00);
      rd(ARTLC_OFF_CNT_LO, 8'h02, 2'b00);
      tally_and_finish();
   end
endmodule : tb_artlc_timer
`default_nettype wire
